// >>> hw/crqd_framer.sv
// Notes on behaviour
// - Descriptor occupies lowest sixteen bytes, first beat
// - Valid stays high through whole packet
// - Stalled beat held until ready high
// - Keep contiguous from descriptor to last payload
// - Keep zeros only in short final beat
// - Last flagged only on final beat
// - First and last byte-valids in first beat
// - Start flag on first beat with descriptor
// - Lane valids only on payload bytes
// - Lane valids contiguous except short writes
// - Zero-length write sends one blank dword
// - Dword mode byte gap from first byte-valid
// - Hint steering tag and type on sideband
// - Aligned mode payload slot by address
// - Aligned mode keep high across gap
// - Memory read is single descriptor beat
// - Read byte-valids present with descriptor
// - Read byte-valids contiguous beyond two dwords
// - Zero-length read: count one, byte-valids zero
// - IO write is descriptor plus one dword
// - Descriptor type field encodes request kind
// - Dword count field, one for IO
`include "crqd_defines.svh"

module crqd_framer import crqd_pkg::*; #(
  parameter int MAX_DW = `CRQD_MAX_DW
) (
  // Clock and reset
  input  wire logic         I_CLK,
  input  wire logic         I_SYS_RST,
  // AHB-Lite register slave
  input  wire logic         I_HSEL,
  input  wire logic [31:0]  I_HADDR,
  input  wire logic [1:0]   I_HTRANS,
  input  wire logic         I_HWRITE,
  input  wire logic [2:0]   I_HSIZE,
  input  wire logic [31:0]  I_HWDATA,
  input  wire logic         I_HREADY,
  output logic      [31:0]  O_HRDATA,
  output logic              O_HREADYOUT,
  output logic              O_HRESP,
  // Request header from link side
  input  wire logic         I_REQ_VALID,
  input  crqd_req_s         I_REQ,
  output logic              O_REQ_READY,
  // Payload dwords from link side
  input  wire logic         I_PAY_VALID,
  input  wire logic [31:0]  I_PAY_DATA,
  output logic              O_PAY_READY,
  // Completer request stream
  output logic              O_REQUEST_STREAM_VALID,
  input  wire logic         I_REQUEST_STREAM_READY,
  output logic      [511:0] O_REQUEST_STREAM_DATA,
  output logic      [15:0]  O_REQUEST_DWORD_KEEP,
  output logic              O_REQUEST_STREAM_LAST,
  output crqd_sb_s          O_REQUEST_SIDEBAND_BUS
);

  localparam int IW    = $clog2(MAX_DW + 24);
  localparam int DEPTH = (MAX_DW + 7 + 15) / 16;
  localparam int AW    = $clog2(DEPTH + 1);

  if (MAX_DW < 1 || MAX_DW > 1024) begin : g_bad_max_dw
    $error("crqd_framer: MAX_DW out of range");
  end

  crqd_state_e    state_q, state_d;
  crqd_req_s      hdr_q;
  logic [1:0]     ctrl_q;
  logic           aln_q;
  logic [IW-1:0]  idx_q, idx_d, slot_q, total_q, fill_end, pay_j;
  logic [IW-1:0]  slot_in, cnt_in, fill_n;
  logic [AW-1:0]  beat_q, beat_d, last_beat;
  logic           take_req, is_pay, lane_adv, pay_rdy_d;
  logic [31:0]    lane_data;
  logic [3:0]     lane_be;
  logic [127:0]   desc;
  logic [IW-1:0]  rem;
  logic [15:0]    keep_d;
  logic [15:0]    pkt_cnt_q;
  logic           wr_pend_q;
  logic [7:0]     ahb_addr_q;
  logic [63:0]    mem_be;
  logic [10:0]    cnt_field;
  logic           sb_start_q, sb_tph_q;
  logic [3:0]     sb_first_q, sb_last_q;
  logic [1:0]     sb_st_type_q;
  logic [7:0]     sb_st_tag_q;

  // ============================================================
  // Request intake
  assign take_req  = (state_q == ST_IDLE) && O_REQ_READY && I_REQ_VALID;
  assign cnt_field = (I_REQ.req_type == `CRQD_TYPE_IOWR) ? `CRQD_IO_DW : I_REQ.dw_count;

  // Payload length and first payload slot of the incoming request
  always_comb begin
    if (I_REQ.req_type == `CRQD_TYPE_MWR) begin
      cnt_in = IW'(I_REQ.dw_count);
    end else if (I_REQ.req_type == `CRQD_TYPE_IOWR) begin
      cnt_in = IW'(1);
    end else begin
      cnt_in = '0;
    end
    if (ctrl_q[`CRQD_CTRL_ALN_BIT] && cnt_in != '0) begin
      slot_in = IW'(`CRQD_DESC_DW) + IW'(I_REQ.dw_addr[1:0]);
    end else begin
      slot_in = IW'(`CRQD_DESC_DW);
    end
  end

  // Header latch at request acceptance
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      hdr_q   <= '0;
      aln_q   <= 1'b0;
      slot_q  <= IW'(`CRQD_DESC_DW);
      total_q <= IW'(`CRQD_DESC_DW);
    end else if (take_req) begin
      hdr_q          <= I_REQ;
      hdr_q.dw_count <= cnt_field;
      aln_q          <= ctrl_q[`CRQD_CTRL_ALN_BIT];
      slot_q         <= slot_in;
      total_q        <= slot_in + cnt_in;
    end
  end

  // ============================================================
  // Descriptor assembly
  always_comb begin
    desc = '0;
    desc[`CRQD_D_AT   +: 2]  = hdr_q.addr_type;
    desc[`CRQD_D_ADDR +: 62] = hdr_q.dw_addr;
    desc[`CRQD_D_DCNT +: 11] = hdr_q.dw_count;
    desc[`CRQD_D_TYPE +: 4]  = hdr_q.req_type;
    desc[`CRQD_D_RID  +: 16] = hdr_q.requester_id;
    desc[`CRQD_D_TAG  +: 8]  = hdr_q.tag;
    desc[`CRQD_D_FN   +: 8]  = hdr_q.target_fn;
    desc[`CRQD_D_BAR  +: 3]  = hdr_q.bar_id;
    desc[`CRQD_D_AP   +: 6]  = hdr_q.bar_aperture;
    desc[`CRQD_D_TC   +: 3]  = hdr_q.tclass;
    desc[`CRQD_D_ATTR +: 3]  = hdr_q.attr;
  end

  // ============================================================
  // Lane content while filling the beat store
  assign fill_end = {total_q[IW-1:4] - ((total_q[3:0] == 4'h0) ? 1'b1 : 1'b0), 4'hf};
  assign pay_j    = idx_q - slot_q;
  assign is_pay   = (idx_q >= slot_q) && (idx_q < total_q);
  assign lane_adv = !is_pay || (O_PAY_READY && I_PAY_VALID);

  always_comb begin
    lane_data = '0;
    lane_be   = 4'h0;
    if (idx_q < IW'(`CRQD_DESC_DW)) begin
      lane_data = desc[idx_q[1:0]*32 +: 32];
    end else if (is_pay) begin
      lane_data = I_PAY_DATA;
      if (pay_j == '0) begin
        lane_be = hdr_q.first_dword_byte_valid;
      end else if (pay_j == total_q - slot_q - IW'(1)) begin
        lane_be = hdr_q.last_dword_byte_valid;
      end else begin
        lane_be = 4'hf;
      end
    end
  end

  // ============================================================
  // Framer state machine
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    beat_d  = beat_q;
    case (state_q)
      ST_IDLE: begin
        if (take_req) begin
          state_d = ST_FILL;
          idx_d   = '0;
        end
      end
      ST_FILL: begin
        if (lane_adv) begin
          if (idx_q == fill_end) begin
            state_d = ST_LOAD;
          end else begin
            idx_d = idx_q + IW'(1);
          end
        end
      end
      ST_LOAD: begin
        state_d = ST_SEND;
        beat_d  = '0;
      end
      ST_SEND: begin
        if (I_REQUEST_STREAM_READY) begin
          if (beat_q == last_beat) begin
            state_d = ST_IDLE;
          end else begin
            beat_d = beat_q + AW'(1);
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // State, lane index and beat index registers
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_q <= ST_IDLE;
      idx_q   <= '0;
      beat_q  <= '0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      beat_q  <= beat_d;
    end
  end

  // Handshake readies toward the link side
  assign pay_rdy_d = (state_d == ST_FILL) && (idx_d >= slot_q) && (idx_d < total_q);

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_REQ_READY <= 1'b0;
      O_PAY_READY <= 1'b0;
    end else begin
      O_REQ_READY <= (state_d == ST_IDLE) && ctrl_q[`CRQD_CTRL_EN_BIT];
      O_PAY_READY <= pay_rdy_d;
    end
  end

  // ============================================================
  // Beat store
  crqd_beat_mem #(
    .LANES (`CRQD_LANES),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_beat_mem (
    .i_clk     (I_CLK),
    .i_rst     (I_SYS_RST),
    .i_wr_en   ((state_q == ST_FILL) && lane_adv),
    .i_wr_addr (AW'(idx_q[IW-1:4])),
    .i_wr_lane (idx_q[3:0]),
    .i_wr_data (lane_data),
    .i_wr_be   (lane_be),
    .i_rd_en   (state_d == ST_SEND),
    .i_rd_addr (beat_d),
    .o_rd_data (O_REQUEST_STREAM_DATA),
    .o_rd_be   (mem_be)
  );

  // ============================================================
  // Keep and framing flags for the beat shown next
  assign last_beat = AW'((total_q - IW'(1)) >> 4);
  assign rem       = total_q - IW'({beat_d, 4'h0});

  always_comb begin
    if (rem >= IW'(`CRQD_LANES)) begin
      keep_d = `CRQD_FULL_KEEP;
    end else begin
      keep_d = ~(`CRQD_FULL_KEEP << rem[3:0]);
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_REQUEST_STREAM_VALID <= 1'b0;
      O_REQUEST_DWORD_KEEP   <= '0;
      O_REQUEST_STREAM_LAST  <= 1'b0;
    end else begin
      O_REQUEST_STREAM_VALID <= (state_d == ST_SEND);
      O_REQUEST_DWORD_KEEP   <= (state_d == ST_SEND) ? keep_d : '0;
      O_REQUEST_STREAM_LAST  <= (state_d == ST_SEND) && (beat_d == last_beat);
    end
  end

  // Sideband fields, byte-valids only in beat zero
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sb_start_q   <= 1'b0;
      sb_first_q   <= 4'h0;
      sb_last_q    <= 4'h0;
      sb_tph_q     <= 1'b0;
      sb_st_type_q <= 2'h0;
      sb_st_tag_q  <= 8'h00;
    end else begin
      sb_start_q <= (state_d == ST_SEND) && (beat_d == '0);
      if ((state_d == ST_SEND) && (beat_d == '0)) begin
        sb_first_q   <= hdr_q.first_dword_byte_valid;
        sb_last_q    <= hdr_q.last_dword_byte_valid;
        sb_tph_q     <= hdr_q.tph_present;
        sb_st_type_q <= hdr_q.tph_st_type;
        sb_st_tag_q  <= hdr_q.tph_st_tag;
      end else begin
        sb_first_q <= 4'h0;
        sb_last_q  <= 4'h0;
      end
    end
  end

  // Sideband bus, lane valids straight from the store
  assign O_REQUEST_SIDEBAND_BUS = {sb_start_q, sb_first_q, sb_last_q, mem_be,
                                   sb_tph_q, sb_st_type_q, sb_st_tag_q};

  // ============================================================
  // AHB-Lite slave, zero wait, always OKAY
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wr_pend_q   <= 1'b0;
      ahb_addr_q  <= 8'h00;
      O_HRDATA    <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      wr_pend_q   <= I_HSEL && I_HREADY && (I_HTRANS == `CRQD_HTRANS_NONSEQ) && I_HWRITE;
      if (I_HSEL && I_HREADY && (I_HTRANS == `CRQD_HTRANS_NONSEQ)) begin
        ahb_addr_q <= I_HADDR[7:0];
        if (I_HADDR[7:0] == `CRQD_REG_CTRL) begin
          O_HRDATA <= {30'h0, ctrl_q};
        end else if (I_HADDR[7:0] == `CRQD_REG_STATUS) begin
          O_HRDATA <= {28'h0, state_q};
        end else if (I_HADDR[7:0] == `CRQD_REG_PKTCNT) begin
          O_HRDATA <= {16'h0, pkt_cnt_q};
        end else begin
          O_HRDATA <= 32'h0000_0000;
        end
      end
    end
  end

  // Control register write in data phase
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_q <= `CRQD_CTRL_RST;
    end else if (wr_pend_q && (ahb_addr_q == `CRQD_REG_CTRL)) begin
      ctrl_q <= I_HWDATA[1:0];
    end
  end

  // Delivered packet counter
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pkt_cnt_q <= 16'h0000;
    end else if (O_REQUEST_STREAM_VALID && I_REQUEST_STREAM_READY && O_REQUEST_STREAM_LAST) begin
      pkt_cnt_q <= pkt_cnt_q + 16'h0001;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_beat_held_stall: assert property (
    O_REQUEST_STREAM_VALID && !I_REQUEST_STREAM_READY |=> O_REQUEST_STREAM_VALID
      && $stable(O_REQUEST_STREAM_DATA) && $stable(O_REQUEST_DWORD_KEEP) && $stable(O_REQUEST_STREAM_LAST))
    else $error("stalled beat changed");

  a_valid_no_gap: assert property (
    O_REQUEST_STREAM_VALID && I_REQUEST_STREAM_READY && !O_REQUEST_STREAM_LAST |=> O_REQUEST_STREAM_VALID
      && !O_REQUEST_SIDEBAND_BUS.packet_start_flag)
    else $error("valid dropped inside packet");

  a_desc_keep_first: assert property (
    O_REQUEST_STREAM_VALID && O_REQUEST_SIDEBAND_BUS.packet_start_flag |-> O_REQUEST_DWORD_KEEP[3:0] == 4'hf
      && O_REQUEST_SIDEBAND_BUS.byte_lane_valid[15:0] == 16'h0000)
    else $error("descriptor lanes wrong");

  a_keep_full_mid: assert property (
    O_REQUEST_STREAM_VALID && !O_REQUEST_STREAM_LAST |-> O_REQUEST_DWORD_KEEP == 16'hffff)
    else $error("partial keep before last beat");

  a_keep_contig_run: assert property (
    O_REQUEST_STREAM_VALID |-> ((O_REQUEST_DWORD_KEEP + 16'h0001) & O_REQUEST_DWORD_KEEP) == 16'h0000
      && O_REQUEST_DWORD_KEEP != 16'h0000)
    else $error("keep not contiguous");

  a_read_one_beat: assert property (
    O_REQUEST_STREAM_VALID && O_REQUEST_SIDEBAND_BUS.packet_start_flag
      && O_REQUEST_STREAM_DATA[78:75] == 4'h0 |-> O_REQUEST_STREAM_LAST && O_REQUEST_DWORD_KEEP == 16'h000f)
    else $error("read not a single descriptor beat");

  a_last_ends_pkt: assert property (
    O_REQUEST_STREAM_VALID && I_REQUEST_STREAM_READY && O_REQUEST_STREAM_LAST |=> !O_REQUEST_STREAM_VALID)
    else $error("beat after last");

  a_first_dword_byte_valid_only: assert property (
    O_REQUEST_STREAM_VALID && !O_REQUEST_SIDEBAND_BUS.packet_start_flag
      |-> O_REQUEST_SIDEBAND_BUS.first_dword_byte_valid == 4'h0)
    else $error("byte-valid outside first beat");

  a_hint_on_side: assert property (
    O_REQUEST_STREAM_VALID && O_REQUEST_SIDEBAND_BUS.packet_start_flag
      |-> O_REQUEST_SIDEBAND_BUS.tph_st_tag == hdr_q.tph_st_tag && O_REQUEST_SIDEBAND_BUS.tph_present == hdr_q.tph_present)
    else $error("hint fields mismatch");

  a_io_one_dword: assert property (
    O_REQUEST_STREAM_VALID && O_REQUEST_SIDEBAND_BUS.packet_start_flag && O_REQUEST_STREAM_DATA[78:75] == 4'h3
      |-> O_REQUEST_STREAM_DATA[74:64] == 11'h001 && O_REQUEST_STREAM_LAST)
    else $error("io write framing wrong");

endmodule // crqd_framer

// >>> hw/crqd_defines.svh
`ifndef CRQD_DEFINES_SVH
`define CRQD_DEFINES_SVH

// ============================================================
// Register map (byte addresses, one word each)
`define CRQD_REG_CTRL       8'h00
`define CRQD_REG_STATUS     8'h04
`define CRQD_REG_PKTCNT     8'h08
`define CRQD_CTRL_RST       2'h1
`define CRQD_CTRL_EN_BIT    0
`define CRQD_CTRL_ALN_BIT   1
`define CRQD_HTRANS_NONSEQ  2'h2

// ============================================================
// Stream geometry
`define CRQD_LANES          16
`define CRQD_DESC_DW        4
`define CRQD_MAX_DW         256
`define CRQD_FULL_KEEP      16'hffff

// ============================================================
// Request type codes and fixed counts
`define CRQD_TYPE_MRD       4'h0
`define CRQD_TYPE_MWR       4'h1
`define CRQD_TYPE_IOWR      4'h3
`define CRQD_IO_DW          11'h001

// ============================================================
// Descriptor field positions (lowest bit)
`define CRQD_D_AT           0
`define CRQD_D_ADDR         2
`define CRQD_D_DCNT         64
`define CRQD_D_TYPE         75
`define CRQD_D_RID          80
`define CRQD_D_TAG          96
`define CRQD_D_FN           104
`define CRQD_D_BAR          112
`define CRQD_D_AP           115
`define CRQD_D_TC           121
`define CRQD_D_ATTR         124

`endif

// >>> hw/crqd_pkg.sv
package crqd_pkg;

  // ============================================================
  // Framer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FILL = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_SEND = 4'b1000
  } crqd_state_e;

  // ============================================================
  // Request header handed over by the link side
  typedef struct packed {
    logic [3:0]  req_type;
    logic [1:0]  addr_type;
    logic [61:0] dw_addr;
    logic [10:0] dw_count;
    logic [15:0] requester_id;
    logic [7:0]  tag;
    logic [7:0]  target_fn;
    logic [2:0]  bar_id;
    logic [5:0]  bar_aperture;
    logic [2:0]  tclass;
    logic [2:0]  attr;
    logic [3:0]  first_dword_byte_valid;
    logic [3:0]  last_dword_byte_valid;
    logic        tph_present;
    logic [1:0]  tph_st_type;
    logic [7:0]  tph_st_tag;
  } crqd_req_s;

  // ============================================================
  // Sideband bus beside each beat
  typedef struct packed {
    logic        packet_start_flag;
    logic [3:0]  first_dword_byte_valid;
    logic [3:0]  last_dword_byte_valid;
    logic [63:0] byte_lane_valid;
    logic        tph_present;
    logic [1:0]  tph_st_type;
    logic [7:0]  tph_st_tag;
  } crqd_sb_s;

endpackage

// >>> hw/crqd_beat_mem.sv
module crqd_beat_mem #(
  parameter int LANES = 16,
  parameter int DEPTH = 17,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Lane write port
  input  wire logic                 i_wr_en,
  input  wire logic [AW-1:0]        i_wr_addr,
  input  wire logic [3:0]           i_wr_lane,
  input  wire logic [31:0]          i_wr_data,
  input  wire logic [3:0]           i_wr_be,
  // Beat read port
  input  wire logic                 i_rd_en,
  input  wire logic [AW-1:0]        i_rd_addr,
  output logic      [LANES*32-1:0]  o_rd_data,
  output logic      [LANES*4-1:0]   o_rd_be
);

  logic [LANES*32-1:0] data_mem [DEPTH];
  logic [LANES*4-1:0]  be_mem   [DEPTH];

  if (LANES != 16 || DEPTH < 1 || (1 << AW) < DEPTH) begin : g_bad_geometry
    $error("crqd_beat_mem: bad geometry");
  end

  // ============================================================
  // Lane write, no reset on storage
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      data_mem[i_wr_addr][i_wr_lane*32 +: 32] <= i_wr_data;
      be_mem[i_wr_addr][i_wr_lane*4 +: 4]     <= i_wr_be;
    end
  end

  // Registered beat read, cleared by reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= '0;
      o_rd_be   <= '0;
    end else if (i_rd_en) begin
      o_rd_data <= data_mem[i_rd_addr];
      o_rd_be   <= be_mem[i_rd_addr];
    end
  end

endmodule // crqd_beat_mem

// >>> testbench/crqd_user_model.sv
module crqd_user_model import crqd_pkg::*; (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Request stream from the block
  input  wire logic         i_valid,
  input  wire logic [511:0] i_data,
  input  wire logic [15:0]  i_keep,
  input  wire logic         i_last,
  input  crqd_sb_s          i_sb,
  output logic              o_ready,
  // Test control and status
  input  wire logic         i_stall,
  output int                o_hold_err,
  output int                o_owed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]   ph_q;
  logic         held_q;
  logic [612:0] snap_q;

  // ============================================================
  // Ready pattern: slow mode takes one beat in three
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_q    <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      ph_q    <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      o_ready <= !i_stall || (ph_q == 2'h2);
    end
  end

  // Stalled beat must come back unchanged
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      held_q     <= 1'b0;
      snap_q     <= '0;
      o_hold_err <= 0;
    end else begin
      if (held_q && snap_q !== {i_data, i_keep, i_last, i_sb}) begin
        o_hold_err <= o_hold_err + 1;
      end
      held_q <= i_valid && !o_ready;
      snap_q <= {i_data, i_keep, i_last, i_sb};
    end
  end

  // Non-posted requests owing a completion elsewhere
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_owed <= 0;
    end else if (i_valid && o_ready && i_sb.packet_start_flag && i_data[78:75] != 4'h1) begin
      o_owed <= o_owed + 1;
    end
  end
endmodule  // crqd_user_model

// >>> testbench/tb.sv
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end

module tb import crqd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // ============================================================
  // Signals
  logic         clk, rst, hsel, hwrite, hreadyout, hresp, stall, ready;
  logic         req_valid, req_ready, pay_valid, pay_ready, s_valid, s_last;
  logic [1:0]   htrans;
  logic [31:0]  haddr, hwdata, hrdata, pay_data;
  logic [511:0] s_data;
  logic [15:0]  s_keep;
  crqd_req_s    req;
  crqd_sb_s     sb;
  int           n_mismatch, comparisons, hold_err, n_pkt, owed;

  crqd_framer dut (
    .I_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
    .O_HRESP(hresp), .I_REQ_VALID(req_valid), .I_REQ(req), .O_REQ_READY(req_ready), .I_PAY_VALID(pay_valid),
    .I_PAY_DATA(pay_data), .O_PAY_READY(pay_ready), .O_REQUEST_STREAM_VALID(s_valid),
    .I_REQUEST_STREAM_READY(ready), .O_REQUEST_STREAM_DATA(s_data), .O_REQUEST_DWORD_KEEP(s_keep),
    .O_REQUEST_STREAM_LAST(s_last), .O_REQUEST_SIDEBAND_BUS(sb));

  crqd_user_model user (
    .i_clk(clk), .i_rst(rst), .i_valid(s_valid), .i_data(s_data), .i_keep(s_keep), .i_last(s_last),
    .i_sb(sb), .o_ready(ready), .i_stall(stall), .o_hold_err(hold_err), .o_owed(owed));

  // ============================================================
  // Common tasks
  task automatic report_and_stop();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Edge at which the slave shows ready
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  // One single-word bus transfer
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    edge_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready();
    rd = hrdata;
  endtask

  function automatic crqd_req_s mk(logic [3:0] t, logic [61:0] a, logic [10:0] c, logic [3:0] f, logic [3:0] l);
    mk = '0;
    mk.req_type = t;
    mk.dw_addr = a;
    mk.dw_count = c;
    mk.first_dword_byte_valid = f;
    mk.last_dword_byte_valid = l;
  endfunction

  // Send a header, feed its payload, judge every beat
  task automatic run_pkt(input crqd_req_s r, input int np, input int slot, input logic [10:0] cnt);
    int b, n, k, tot, nb, ln, pk;
    logic hs, ps;
    logic [15:0] ek;
    logic [63:0] ev;
    tot = (np == 0) ? 4 : slot + np;
    nb = (tot + 15) / 16;
    b = 0;
    n = 0;
    k = 0;
    req <= r;
    req_valid <= 1'b1;
    pay_data <= 32'hd000_0000;
    pay_valid <= (np > 0);
    while (b < nb && n < 3000) begin
      @(negedge clk);
      n++;
      hs = req_valid & req_ready;
      ps = pay_valid & pay_ready;
      if (b > 0) `CHK(s_valid, 1'b1, "valid gap")
      if (s_valid && ready) begin
        for (ln = 0; ln < 16; ln++) begin
          pk = b * 16 + ln - slot;
          ek[ln] = (b * 16 + ln) < tot;
          ev[ln*4 +: 4] = (np == 0 || pk < 0 || pk >= np) ? 4'h0 : (pk == 0) ? r.first_dword_byte_valid :
                          (pk == np - 1) ? r.last_dword_byte_valid : 4'hf;
          if (np > 0 && pk >= 0 && pk < np) `CHK(s_data[ln*32 +: 32], 32'hd000_0000 + 32'(pk), "payload")
        end
        `CHK(s_keep, ek, "keep")
        `CHK(s_last, logic'(b == nb - 1), "last")
        `CHK(sb.packet_start_flag, logic'(b == 0), "start")
        `CHK(sb.byte_lane_valid, ev, "lane valid")
        `CHK(sb.first_dword_byte_valid, (b == 0) ? r.first_dword_byte_valid : 4'h0, "first bv")
        `CHK(sb.last_dword_byte_valid, (b == 0) ? r.last_dword_byte_valid : 4'h0, "last bv")
        if (b == 0) begin
          `CHK(s_data[63:2], r.dw_addr, "address")
          `CHK(s_data[74:64], cnt, "count")
          `CHK(s_data[78:75], r.req_type, "type")
          `CHK({sb.tph_present, sb.tph_st_type, sb.tph_st_tag}, {r.tph_present, r.tph_st_type, r.tph_st_tag}, "hint")
        end
        b++;
      end
      @(posedge clk);
      if (hs) req_valid <= 1'b0;
      if (ps) begin
        k++;
        pay_data <= 32'hd000_0000 + 32'(k);
        pay_valid <= (k < np);
      end
    end
    if (n >= 3000) begin
      n_mismatch++;
      report_and_stop();
    end
    `CHK(k, np, "payload taken")
    n_pkt++;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] d0, d1, d2, d3;
    ahb(1'b1, 32'h0000_000c, 32'hffff_ffff, d0);
    ahb(1'b0, 32'h0000_000c, 32'h0, d1);
    ahb(1'b0, 32'h0, 32'h0, d0);
    ahb(1'b0, 32'h0000_0004, 32'h0, d2);
    ahb(1'b1, 32'h0, 32'h0, d3);
    repeat (3) @(negedge clk);
    `CHK({d0, d1, d2, hresp, req_ready}, {32'h1, 32'h0, 32'h1, 2'b00}, "regs")
    @(posedge clk);
    ahb(1'b1, 32'h0, 32'h1, d3);
  endtask

  task automatic t_read();
    stall <= 1'b1;
    run_pkt(mk(4'h0, 62'h1000, 11'd8, 4'hf, 4'h7), 0, 4, 11'd8);
    run_pkt(mk(4'h0, 62'h1020, 11'd1, 4'h0, 4'h0), 0, 4, 11'd1);
  endtask

  task automatic t_write();
    crqd_req_s r;
    r = mk(4'h1, 62'h2003, 11'd30, 4'hc, 4'h3);
    r.tph_present = 1'b1;
    r.tph_st_type = 2'h2;
    r.tph_st_tag = 8'h5a;
    run_pkt(r, 30, 4, 11'd30);
    stall <= 1'b0;
    run_pkt(mk(4'h1, 62'h2100, 11'd1, 4'h0, 4'h0), 1, 4, 11'd1);
  endtask

  task automatic t_aligned();
    logic [31:0] d;
    ahb(1'b1, 32'h0, 32'h3, d);
    run_pkt(mk(4'h3, 62'h3002, 11'd5, 4'h6, 4'h0), 1, 6, 11'd1);
    run_pkt(mk(4'h1, 62'h3103, 11'd2, 4'h8, 4'h1), 2, 7, 11'd2);
    ahb(1'b1, 32'h0, 32'h1, d);
  endtask

  // ============================================================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    logic [31:0] d;
    {rst, hsel, hwrite, stall, req_valid, pay_valid} = 6'b100000;
    {htrans, haddr, hwdata, pay_data} = '0;
    req = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_read();
    t_write();
    t_aligned();
    ahb(1'b0, 32'h0000_0008, 32'h0, d);
    `CHK(d[15:0], 16'(n_pkt), "packets")
    `CHK(hold_err, 0, "stall hold")
    `CHK(owed, 3, "non-posted owed")
    report_and_stop();
  end
endmodule  // tb
